/* hw/cphu_pkg.sv */
// Constants and types for the prefetch hint unit
package cphu_pkg;
  localparam int ADDR_W   = 64;
  localparam int OFFS_W   = 16;
  localparam int HINT_W   = 5;
  localparam int CCA_W    = 3;
  localparam int LINE_SH  = 5;
  localparam logic [2:0] CCA_UNCACHED = 3'h2;
  localparam logic [4:0] H_LOAD    = 5'h00;
  localparam logic [4:0] H_STORE   = 5'h01;
  localparam logic [4:0] H_LD_STRM = 5'h04;
  localparam logic [4:0] H_ST_STRM = 5'h05;
  localparam logic [4:0] H_LD_RET  = 5'h06;
  localparam logic [4:0] H_ST_RET  = 5'h07;
  localparam logic [4:0] H_WB_INV  = 5'h19;
  localparam logic [4:0] H_ZERO    = 5'h1E;

  // Memory command kinds issued toward the cache
  typedef enum logic [2:0] {
    CMD_NONE    = 3'h0,
    CMD_FETCH   = 3'h1,
    CMD_WB_INV  = 3'h2,
    CMD_ZERO    = 3'h3,
    CMD_VICT_WB = 3'h4
  } cphu_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_XLAT  = 3'b001,
    ST_ISSUE = 3'b011,
    ST_WAIT  = 3'b010,
    ST_FILL  = 3'b110
  } cphu_state_e;

  // Hint action class
  typedef struct packed {
    logic act;
    logic store;
    logic stream;
    logic retain;
    logic wbinv;
    logic zero;
  } cphu_hint_s;

  function automatic cphu_hint_s cphu_decode(input logic [4:0] h);
    cphu_hint_s r;
    r = '0;
    case (h)
      H_LOAD:    r = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      H_STORE:   r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      H_LD_STRM: r = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      H_ST_STRM: r = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      H_LD_RET:  r = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      H_ST_RET:  r = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      H_WB_INV:  r = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      H_ZERO:    r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      default:   r = '0;
    endcase
    return r;
  endfunction
endpackage

/* hw/cphu_addr_gen.sv */
// Effective address former for both prefetch forms
`timescale 1ns/10ps
module cphu_addr_gen
  import cphu_pkg::*;
(
  input  wire logic [ADDR_W-1:0] baseVal,
  input  wire logic [ADDR_W-1:0] indexVal,
  input  wire logic [OFFS_W-1:0] offsetVal,
  input  wire logic              isIndexed,
  output logic      [ADDR_W-1:0] effAddr
);
  wire logic [ADDR_W-1:0] sextOffs;
  assign sextOffs = {{(ADDR_W-OFFS_W){offsetVal[OFFS_W-1]}}, offsetVal};
  // Only the addend differs between the forms
  assign effAddr = baseVal + (isIndexed ? indexVal : sextOffs);
endmodule

/* hw/cphu_placement.sv */
// Way placement keeping streamed lines away from retained ones
`timescale 1ns/10ps
module cphu_placement
  import cphu_pkg::*;
(
  input  wire logic       isStream,
  input  wire logic       isRetain,
  input  wire logic [3:0] wayLocked,
  input  wire logic [3:0] wayRetained,
  input  wire logic [1:0] lruWay,
  output logic [1:0]      victimWay,
  output logic            victimOk
);
  // Streamed data is confined to way 0 and gets no way if way 0 is retained; retained avoids it
  wire logic [3:0] allowed;
  wire logic [3:0] strmMask;
  wire logic [3:0] retMask;
  assign strmMask = 4'h1 & ~wayRetained;
  assign retMask  = 4'hE;
  assign allowed = ~wayLocked & (isStream ? strmMask :
                   isRetain ? retMask : ~wayRetained);
  assign victimOk = |allowed;
  assign victimWay = allowed[lruWay] ? lruWay :
                     allowed[1] ? 2'h1 : allowed[2] ? 2'h2 :
                     allowed[3] ? 2'h3 : 2'h0;
endmodule

/* hw/cphu_top.sv */
// Prefetch hint unit: address, translation, hint action sequencing
`timescale 1ns/10ps
module cphu_top
  import cphu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              issueValid,
  input  wire logic              isIndexed,
  input  wire logic              fpuUsable,
  input  wire logic              fpuPresent,
  input  wire logic [HINT_W-1:0] hintField,
  input  wire logic [ADDR_W-1:0] baseVal,
  input  wire logic [ADDR_W-1:0] indexVal,
  input  wire logic [OFFS_W-1:0] offsetVal,
  input  wire logic              xlatDone,
  input  wire logic              xlatHit,
  input  wire logic              xlatMapped,
  input  wire logic              xlatAddrErr,
  input  wire logic [ADDR_W-1:0] physAddr,
  input  wire logic [CCA_W-1:0]  cacheCoherencyAttr,
  input  wire logic              cacheHit,
  input  wire logic              hitLocked,
  input  wire logic              hitDirty,
  input  wire logic [3:0]        wayLocked,
  input  wire logic [3:0]        wayRetained,
  input  wire logic [3:0]        wayValidDirty,
  input  wire logic [1:0]        lruWay,
  input  wire logic              memReady,
  input  wire logic              memDone,
  output logic                   retireValid,
  output logic                   excCopUnusable,
  output logic                   excReservedInstr,
  output logic                   regWriteEn,
  output logic                   xlatReq,
  output logic      [ADDR_W-1:0] virtualAddr,
  output logic                   memReq,
  output logic      [2:0]        memCmd,
  output logic      [ADDR_W-1:0] memAddr,
  output logic      [CCA_W-1:0]  memCca,
  output logic                   memStoreIntent,
  output logic                   memStream,
  output logic                   memRetain,
  output logic      [1:0]        memWay,
  output logic                   busy
);
  cphu_state_e     state_q, state_d;
  cphu_hint_s      hint_q;
  logic            retire_q, copExc_q, riExc_q, xreq_q;
  logic [ADDR_W-1:0] va_q, pa_q;
  logic [CCA_W-1:0]  cca_q;
  logic            mreq_q;
  cphu_cmd_e       mcmd_q;
  logic [1:0]      way_q;
  logic            zeroPend_q;
  logic            busy_q, regWr_q;

  // Every check below runs on the core clock and rests in reset
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  wire logic [ADDR_W-1:0] effAddr;
  wire cphu_hint_s        hintDec;
  wire logic              fpuBad;
  wire logic              accept;
  wire logic              xlatOk;
  wire logic              cachedOk;
  wire logic [1:0]        victimWay;
  wire logic              victimOk;
  wire logic              victimDirty;
  wire logic              zeroMiss;
  wire logic              doFetch;
  wire logic              doWbInv;

  cphu_addr_gen u_addr (
    .baseVal   (baseVal),
    .indexVal  (indexVal),
    .offsetVal (offsetVal),
    .isIndexed (isIndexed),
    .effAddr   (effAddr)
  );

  cphu_placement u_place (
    .isStream    (hint_q.stream),
    .isRetain    (hint_q.retain),
    .wayLocked   (wayLocked),
    .wayRetained (wayRetained),
    .lruWay      (lruWay),
    .victimWay   (victimWay),
    .victimOk    (victimOk)
  );

  // Hint decoded identically for both forms; unused codes are no-ops
  assign hintDec = cphu_decode(hintField);
  assign fpuBad = isIndexed & ~(fpuPresent & fpuUsable);
  assign accept = issueValid & (state_q == ST_IDLE) & ~fpuBad;
  // Address errors and TLB misses silently drop the prefetch
  assign xlatOk = (xlatHit | ~xlatMapped) & ~xlatAddrErr;
  assign cachedOk = cacheCoherencyAttr != CCA_UNCACHED;
  assign victimDirty = wayValidDirty[victimWay];
  assign zeroMiss = hint_q.zero & ~cacheHit & victimOk;
  // Locked lines are left alone; only writeback invalidate acts on a resident line
  assign doFetch = hint_q.act & ~hint_q.wbinv & ~hint_q.zero &
                   ~cacheHit & victimOk;
  assign doWbInv = hint_q.wbinv & cacheHit & hitDirty & ~hitLocked;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (accept && hintDec.act) state_d = ST_XLAT;
      ST_XLAT:  if (xlatDone) state_d = (xlatOk && cachedOk) ?
                                        ST_ISSUE : ST_IDLE;
      ST_ISSUE: begin
        if (zeroMiss || doFetch || doWbInv) state_d = ST_WAIT;
        else state_d = ST_IDLE;
      end
      ST_WAIT:  if (memReady) state_d = ST_FILL;
      ST_FILL:  if (memDone) state_d = zeroPend_q ? ST_WAIT : ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Retire and exceptions do not wait for the fetch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      retire_q <= 1'b0;
      copExc_q <= 1'b0;
      riExc_q  <= 1'b0;
    end else begin
      retire_q <= issueValid & (state_q == ST_IDLE) & ~fpuBad;
      copExc_q <= issueValid & isIndexed & fpuPresent & ~fpuUsable;
      riExc_q  <= issueValid & isIndexed & ~fpuPresent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hint_q <= '0;
      va_q   <= '0;
      xreq_q <= 1'b0;
    end else begin
      xreq_q <= accept & hintDec.act;
      if (accept) begin
        hint_q <= hintDec;
        va_q   <= effAddr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pa_q  <= '0;
      cca_q <= '0;
    end else if (state_q == ST_XLAT && xlatDone) begin
      pa_q  <= {physAddr[ADDR_W-1:LINE_SH], {LINE_SH{1'b0}}};
      cca_q <= cacheCoherencyAttr;
    end
  end

  // Zero-allocate with dirty victim: writeback first, then zero fill
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mreq_q     <= 1'b0;
      mcmd_q     <= CMD_NONE;
      way_q      <= 2'h0;
      zeroPend_q <= 1'b0;
    end else begin
      if (state_q == ST_ISSUE) begin
        mreq_q <= zeroMiss | doFetch | doWbInv;
        way_q  <= victimWay;
        zeroPend_q <= zeroMiss & victimDirty;
        if (zeroMiss)
          mcmd_q <= victimDirty ? CMD_VICT_WB : CMD_ZERO;
        else if (doWbInv)
          mcmd_q <= CMD_WB_INV;
        else if (doFetch)
          mcmd_q <= CMD_FETCH;
        else
          mcmd_q <= CMD_NONE;
      end else if (state_q == ST_WAIT && memReady) begin
        mreq_q <= 1'b0;
      end else if (state_q == ST_FILL && memDone) begin
        if (zeroPend_q) begin
          mreq_q     <= 1'b1;
          mcmd_q     <= CMD_ZERO;
          zeroPend_q <= 1'b0;
        end else begin
          mcmd_q <= CMD_NONE;
        end
      end
    end
  end

  // Busy has its own flop so the pipeline never sees a decode glitch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busy_q  <= 1'b0;
      regWr_q <= 1'b0;
    end else begin
      busy_q  <= state_d != ST_IDLE;
      regWr_q <= 1'b0;
    end
  end

  assign retireValid      = retire_q;
  assign excCopUnusable   = copExc_q;
  assign excReservedInstr = riExc_q;
  assign regWriteEn       = regWr_q;
  assign xlatReq          = xreq_q;
  assign virtualAddr      = va_q;
  assign memReq           = mreq_q;
  assign memCmd           = mcmd_q;
  assign memAddr          = pa_q;
  assign memCca           = cca_q;
  assign memStoreIntent   = hint_q.store;
  assign memStream        = hint_q.stream;
  assign memRetain        = hint_q.retain;
  assign memWay           = way_q;
  assign busy             = busy_q;

  // Steps of the dirty-victim zero allocate
  sequence s_victim_wb_done;
    state_q == ST_FILL && memDone && zeroPend_q;
  endsequence

  sequence s_zero_fill_req;
    mreq_q && mcmd_q == CMD_ZERO;
  endsequence

  sequence s_dirty_zero_miss;
    state_q == ST_ISSUE && hint_q.zero && !cacheHit && victimOk &&
    wayValidDirty[victimWay];
  endsequence

  a_no_uncached_op: assert property (
    $rose(mreq_q) |-> cca_q != CCA_UNCACHED)
    else $error("memory request to uncached location");
  a_reserved_noop: assert property (
    accept && !hintDec.act |=> state_q == ST_IDLE)
    else $error("reserved hint started work");
  a_tlb_miss_drop: assert property (
    state_q == ST_XLAT && xlatDone && xlatMapped && !xlatHit |=>
    !mreq_q && state_q == ST_IDLE)
    else $error("prefetch went on after translation miss");
  a_retire_next: assert property (
    accept |=> retireValid)
    else $error("prefetch did not retire next cycle");
  a_fpu_exc: assert property (
    issueValid && isIndexed && !fpuPresent |=>
    excReservedInstr && !retireValid)
    else $error("missing reserved instruction exception");
  a_zero_hit_idle: assert property (
    state_q == ST_ISSUE && hint_q.zero && cacheHit |=> state_q == ST_IDLE)
    else $error("zero allocate acted on hit");
  a_no_reg_write: assert property (
    retireValid |-> !regWriteEn)
    else $error("prefetch wrote a register");
  a_wb_then_zero: assert property (
    s_victim_wb_done |=> s_zero_fill_req)
    else $error("zero fill did not follow victim writeback");
  a_victim_wb_first: assert property (
    s_dirty_zero_miss |=> mreq_q && mcmd_q == CMD_VICT_WB)
    else $error("dirty victim not written back first");
  a_wbinv_dirty_hit: assert property (
    state_q == ST_ISSUE && hint_q.wbinv && cacheHit && hitDirty &&
    !hitLocked |=> mreq_q && mcmd_q == CMD_WB_INV)
    else $error("writeback invalidate not issued");
  a_locked_no_req: assert property (
    state_q == ST_ISSUE && cacheHit && hitLocked |=> !mreq_q)
    else $error("prefetch touched a locked line");
  a_stream_spares_ret: assert property (
    state_q == ST_ISSUE && doFetch && hint_q.stream |->
    !wayRetained[victimWay])
    else $error("streamed fetch evicts retained way");
  a_retain_way: assert property (
    state_q == ST_ISSUE && doFetch && hint_q.retain |-> victimWay != 2'h0)
    else $error("retained fetch placed in streaming way");
  a_line_aligned: assert property (
    mreq_q |-> pa_q[LINE_SH-1:0] == '0)
    else $error("memory address not line aligned");
  a_exc_no_retire: assert property (
    retireValid |-> !excCopUnusable && !excReservedInstr)
    else $error("prefetch retired and faulted together");
  a_uncached_drop: assert property (
    state_q == ST_XLAT && xlatDone && !cachedOk |=> state_q == ST_IDLE)
    else $error("uncached prefetch was not dropped");
  a_xlat_on_accept: assert property (
    accept && hintDec.act |=> xlatReq && state_q == ST_XLAT)
    else $error("active hint did not request translation");
  a_req_held: assert property (
    state_q == ST_WAIT && !memReady |=> mreq_q)
    else $error("memory request dropped before acceptance");
endmodule

/* verif/cphu_mem_model.sv */
// Translation and cache side model answering the prefetch unit
`timescale 1ns/10ps
module cphu_mem_model
  import cphu_pkg::*;
#(
  parameter logic [ADDR_W-1:0] PA = 64'h0000_1234_5678_9ABC
)
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              slow,
  input  wire logic              xlatReq,
  input  wire logic              memReq,
  output logic                   xlatDone,
  output logic      [ADDR_W-1:0] physAddr,
  output logic                   memReady,
  output logic                   memDone
);
  int   xc;
  int   mc;
  int   dc;
  logic xp;
  logic dp;
  // Address only means something with the answer; otherwise it is scrambled
  assign physAddr = xlatDone ? PA : ~PA;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {xp, dp, xlatDone, memReady, memDone} <= '0;
      xc <= 0;
      mc <= 0;
      dc <= 0;
    end else begin
      xlatDone <= 1'b0;
      memReady <= 1'b0;
      memDone  <= 1'b0;
      if (xlatReq) begin
        xp <= 1'b1;
        xc <= slow ? 6 : 0;
      end else if (xp && xc == 0) begin
        xp       <= 1'b0;
        xlatDone <= 1'b1;
      end else if (xp) begin
        xc <= xc - 1;
      end
      // One accept pulse per request, completion some cycles later
      if (memReq && !memReady && !dp) begin
        if (mc >= (slow ? 5 : 0)) begin
          memReady <= 1'b1;
          mc       <= 0;
          dp       <= 1'b1;
          dc       <= 0;
        end else begin
          mc <= mc + 1;
        end
      end
      if (dp) begin
        if (dc >= (slow ? 7 : 1)) begin
          memDone <= 1'b1;
          dp      <= 1'b0;
        end else begin
          dc <= dc + 1;
        end
      end
    end
  end
endmodule

/* verif/cache_prefetch_hint_unit_tb.sv */
// Self-checking bench for the prefetch hint unit
`timescale 1ns/10ps
module cache_prefetch_hint_unit_tb;
  import cphu_pkg::*;
  typedef struct {
    logic [4:0] h; logic ix; logic [1:0] fpu; logic [63:0] b;
    logic [63:0] x; logic [2:0] cca; logic [5:0] f; logic [3:0] vd;
    logic [1:0] lru; logic [1:0] ex; logic xr; logic [2:0] c1;
    logic [2:0] cl;
  } cphu_row_s;
  localparam logic [63:0] LA = 64'h0000_1234_5678_9AA0;
  logic core_clk = 0, rstn = 0, issueValid = 0, isIndexed = 0;
  logic fpuUsable = 1, fpuPresent = 1, xlatHit = 0, xlatMapped = 0;
  logic xlatAddrErr = 0, cacheHit = 0, hitLocked = 0, hitDirty = 0;
  logic slow = 0, memReady, memDone, xlatDone;
  logic [4:0] hintField = '0;
  logic [63:0] baseVal = '0, indexVal = '0, physAddr;
  logic [15:0] offsetVal = '0;
  logic [2:0] cacheCoherencyAttr = '0;
  logic [3:0] wayLocked = '0, wayRetained = 4'hE, wayValidDirty = '0;
  logic [1:0] lruWay = '0, memWay;
  logic retireValid, excCopUnusable, excReservedInstr, regWriteEn, xlatReq;
  logic memReq, memStoreIntent, memStream, memRetain, busy;
  logic [63:0] virtualAddr, memAddr;
  logic [2:0] memCmd, memCca;
  int mismatches = 0, check_count = 0, k;
  cphu_row_s rows[17] = '{
    '{0, 0, 3, 'h1000, 'hFFF0, 3, 'h30, 0, 0, 0, 1, 1, 1},
    '{1, 1, 3, 'h1000, 'hFFF0, 3, 'h30, 0, 0, 0, 1, 1, 1},
    '{4, 0, 3, 'h2000, 'h0040, 3, 'h30, 0, 3, 0, 1, 1, 1},
    '{5, 0, 3, 'h2000, 'h0040, 3, 'h30, 0, 3, 0, 1, 1, 1},
    '{6, 0, 3, 'h2000, 'h0040, 3, 'h30, 0, 0, 0, 1, 1, 1},
    '{7, 1, 3, 'h2000, 'h0040, 3, 'h30, 0, 0, 0, 1, 1, 1},
    '{25, 0, 3, 'h3000, 'h0008, 3, 'h36, 0, 0, 0, 1, 2, 2},
    '{25, 0, 3, 'h3000, 'h0008, 3, 'h34, 0, 0, 0, 1, 0, 0},
    '{30, 0, 3, 'h3000, 'h0008, 3, 'h34, 0, 0, 0, 1, 0, 0},
    '{30, 0, 3, 'h3000, 'h0008, 3, 'h30, 0, 2, 0, 1, 3, 3},
    '{30, 1, 3, 'h3000, 'h0008, 3, 'h30, 'hF, 2, 0, 1, 4, 3},
    '{0, 0, 3, 'h1000, 'h0010, 2, 'h30, 0, 0, 0, 1, 0, 0},
    '{0, 0, 3, 'h1000, 'h0010, 3, 'h10, 0, 0, 0, 1, 0, 0},
    '{0, 0, 3, 'h1000, 'h0010, 3, 'h38, 0, 0, 0, 1, 0, 0},
    '{0, 0, 3, 'h1000, 'h0010, 3, 'h35, 0, 0, 0, 1, 0, 0},
    '{0, 1, 2, 'h1000, 'h0010, 3, 'h30, 0, 0, 2, 0, 0, 0},
    '{0, 1, 0, 'h1000, 'h0010, 3, 'h30, 0, 0, 1, 0, 0, 0}};
  cphu_top uut (
    .core_clk(core_clk), .rstn(rstn), .issueValid(issueValid),
    .isIndexed(isIndexed), .fpuUsable(fpuUsable), .fpuPresent(fpuPresent),
    .hintField(hintField), .baseVal(baseVal), .indexVal(indexVal),
    .offsetVal(offsetVal), .xlatDone(xlatDone), .xlatHit(xlatHit),
    .xlatMapped(xlatMapped), .xlatAddrErr(xlatAddrErr),
    .physAddr(physAddr), .cacheCoherencyAttr(cacheCoherencyAttr),
    .cacheHit(cacheHit), .hitLocked(hitLocked), .hitDirty(hitDirty),
    .wayLocked(wayLocked), .wayRetained(wayRetained),
    .wayValidDirty(wayValidDirty), .lruWay(lruWay), .memReady(memReady),
    .memDone(memDone), .retireValid(retireValid),
    .excCopUnusable(excCopUnusable), .excReservedInstr(excReservedInstr),
    .regWriteEn(regWriteEn), .xlatReq(xlatReq), .virtualAddr(virtualAddr),
    .memReq(memReq), .memCmd(memCmd), .memAddr(memAddr), .memCca(memCca),
    .memStoreIntent(memStoreIntent), .memStream(memStream),
    .memRetain(memRetain), .memWay(memWay), .busy(busy));
  cphu_mem_model pm (.core_clk(core_clk), .rstn(rstn), .slow(slow),
    .xlatReq(xlatReq), .memReq(memReq), .xlatDone(xlatDone),
    .physAddr(physAddr), .memReady(memReady), .memDone(memDone));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run(input cphu_row_s r);
    logic [2:0] c1, cl; logic [1:0] w; logic [63:0] va; int n;
    c1 = '0; cl = '0; w = '0;
    va = r.ix ? r.b + r.x : r.b + {{48{r.x[15]}}, r.x[15:0]};
    @(posedge core_clk);
    hintField <= r.h; isIndexed <= r.ix; {fpuPresent, fpuUsable} <= r.fpu;
    baseVal <= r.b; indexVal <= r.x; offsetVal <= r.x[15:0];
    cacheCoherencyAttr <= r.cca; wayValidDirty <= r.vd; lruWay <= r.lru;
    {xlatHit, xlatMapped, xlatAddrErr, cacheHit, hitDirty, hitLocked} <= r.f;
    issueValid <= 1'b1;
    @(posedge core_clk);
    issueValid <= 1'b0;
    #1;
    chk("retire", retireValid, ~|r.ex);
    chk("exc", {excCopUnusable, excReservedInstr}, r.ex);
    chk("xreq", xlatReq, r.xr);
    if (r.xr) chk("virtual_addr", virtualAddr, va);
    for (n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
      chk("regwr", regWriteEn, 1'b0);
      if (memReq === 1'b1) cl = memCmd;
      if (memReq === 1'b1 && c1 == 0) begin
        c1 = memCmd; w = memWay;
        chk("cca", memCca, r.cca);
        if (memCmd != 3'h4) chk("addr", memAddr, LA);
        chk("st", memStoreIntent, r.h inside {1, 5, 7, 30});
        chk("strm", memStream, r.h inside {4, 5});
        chk("ret", memRetain, r.h inside {6, 7});
      end
    end
    chk("hang", n < 200, 1'b1);
    chk("first", c1, r.c1);
    chk("last", cl, r.cl);
    if (r.h inside {4, 5} && r.c1 != 0) chk("sway", w, 2'h0);
    if (r.h inside {6, 7}) chk("rway", w != 0, 1'b1);
    $display("test %0d done", k++);
  endtask
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    cphu_row_s r;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("rbusy", {busy, retireValid, memReq, xlatReq}, 4'h0);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      foreach (rows[i]) run(rows[i]);
    end
    // Sweep every hint on a clean miss: 25 finds nothing dirty, 30 zeroes
    for (int h = 0; h < 32; h++) begin
      r = rows[0];
      r.h = h[4:0];
      if (!(h inside {0, 1, 4, 5, 6, 7, 25, 30})) r.xr = 0;
      if (!(h inside {0, 1, 4, 5, 6, 7, 30})) r.c1 = 0;
      if (h == 30) r.c1 = CMD_ZERO;
      r.cl = r.c1;
      run(r);
    end
    // Unmapped needs no TLB entry; locked lines and ways stay untouched
    r = rows[0];
    r.f = 6'h00;
    run(r);
    r = rows[6];
    r.f = 6'h37;
    r.c1 = 0;
    r.cl = 0;
    run(r);
    @(posedge core_clk);
    wayLocked <= 4'hF;
    r = rows[0];
    r.c1 = 0;
    r.cl = 0;
    run(r);
    @(posedge core_clk);
    wayLocked <= 4'h0;
    // Second issue while busy must be dropped without a retire
    @(posedge core_clk);
    hintField  <= H_LOAD;
    isIndexed  <= 1'b0;
    issueValid <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("take", retireValid, 1'b1);
    @(posedge core_clk);
    issueValid <= 1'b0;
    #1;
    chk("drop", retireValid, 1'b0);
    // Reset in mid-operation clears everything
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("mrst", {busy, memReq, retireValid}, 3'h0);
    run(rows[9]);
    $display("test %0d done", k++);
    give_verdict();
  end
endmodule
